// ==== design/bbs_pkg.sv ====
// Constants and types for the AXI4 block RAM burst slave.
// Assumes one clock, a synchronous active-low reset, and that an AXI4
// master or interconnect sits on the far side of the channels.

package bbs_pkg;

   // Data path and memory geometry
   // bus width fixed
   localparam int DATA_W     = 32;
   localparam int NBYTES     = DATA_W / 8;
   localparam int ADDR_W     = 12;
   localparam int WORD_LO    = 2;
   localparam int MEM_DEPTH  = 1024;
   localparam int FIFO_DEPTH = 8;

   // Burst type codes
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR  = 2'h1;
   localparam logic [1:0] BURST_WRAP  = 2'h2;

   // Transfer size codes
   localparam logic [2:0] SIZE_HALF = 3'h1;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   localparam logic [1:0] RESP_OKAY = 2'h0;

   // Operating modes; the build mode selects low-order address decoding
   localparam logic [1:0] MODE_MEM      = 2'h0;
   localparam logic [1:0] MODE_LITE_MEM = 2'h1;
   localparam logic [1:0] MODE_PERI     = 2'h2;
   localparam logic [1:0] MODE_LITE_PER = 2'h3;
   localparam logic [1:0] BUILD_MODE    = MODE_MEM;

   // Address channel contents, shared by write and read
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  len;
      logic [2:0]  size;
      logic [1:0]  burst;
   } bbs_ach_t;

   // One read beat as it travels through the buffer
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              last;
   } bbs_rbeat_t;

   localparam int RBEAT_W = $bits(bbs_rbeat_t);

endpackage

// ==== design/bbs_slave.sv ====
// AXI4 slave front end for a 32-bit by 1024-word block RAM, with its
// read data buffer.
// Assumes a master that keeps AXI4 channel rules; IDs are not carried.

`timescale 1ns/10ps

// ****************************************************************
// Buffer
// ****************************************************************

module bbs_fifo
   import bbs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)(
   input  wire logic                       i_clk,
   input  wire logic                       i_nrst,
   input  wire logic                       i_in_valid,
   input  wire logic [WIDTH-1:0]           i_in_data,
   output logic                            o_in_ready,
   output logic                            o_out_valid,
   output logic [WIDTH-1:0]                o_out_data,
   input  wire logic                       i_out_ready,
   output logic [$clog2(DEPTH+1)-1:0]      o_count
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic [CW-1:0]    cnt_r;
   logic             push;
   logic             pop;

   // Full and empty come from the occupancy count alone
   assign o_in_ready  = (cnt_r != CW'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem[rp_r];
   assign o_count     = cnt_r;
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_r] <= i_in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= PW'(wp_r + 1'b1);
         end
         if (pop) begin
            rp_r <= PW'(rp_r + 1'b1);
         end
         cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
      end
   end
endmodule

// ****************************************************************
// Slave
// ****************************************************************

module bbs_slave
   import bbs_pkg::*;
(
   input  wire logic              I_CLK,
   input  wire logic              I_NRST,
   input  wire logic              I_AWVALID,
   input  wire bbs_ach_t          I_AW,
   output logic                   O_AWREADY,
   input  wire logic              I_WVALID,
   input  wire logic [DATA_W-1:0] I_WDATA,
   input  wire logic [NBYTES-1:0] I_WSTRB,
   input  wire logic              I_WLAST,
   output logic                   O_WREADY,
   output logic                   O_BVALID,
   output logic [1:0]             O_BRESP,
   input  wire logic              I_BREADY,
   input  wire logic              I_ARVALID,
   input  wire bbs_ach_t          I_AR,
   output logic                   O_ARREADY,
   output logic                   O_RVALID,
   output logic [DATA_W-1:0]      O_RDATA,
   output logic [1:0]             O_RRESP,
   output logic                   O_RLAST,
   input  wire logic              I_RREADY
);
   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_DATA = 2'b01,
      WS_RESP = 2'b10
   } bbs_wst_t;

   typedef enum logic {
      RS_IDLE  = 1'b0,
      RS_BURST = 1'b1
   } bbs_rst_t;

   // index width from depth; a depth of 2 needs one bit
   localparam int IDX_W = $clog2(MEM_DEPTH);
   localparam int CNT_W = $clog2(FIFO_DEPTH+1);

   // ****************************************************************
   // Address helpers
   // ****************************************************************

   // Mask of the wrap region, one less than length times size
   function automatic logic [ADDR_W-1:0] f_wmask(input bbs_ach_t c);
      f_wmask = ADDR_W'((({4'h0, c.len} + 12'h1) << c.size) - 12'h1);
   endfunction

   // Next byte address of a burst
   function automatic logic [ADDR_W-1:0] f_next(
      input logic [ADDR_W-1:0] a,
      input bbs_ach_t          c
   );
      logic [ADDR_W-1:0] step;
      logic [ADDR_W-1:0] wm;
      step = ADDR_W'(12'h1 << c.size);
      wm   = f_wmask(c);
      unique case (c.burst)
         BURST_WRAP:
            f_next = (a & ~wm) | (ADDR_W'(a + step) & wm);
         // first step realigns an unaligned start
         BURST_INCR:
            f_next = ADDR_W'((a & ~ADDR_W'(step - 12'h1)) + step);
         default:
            f_next = a;
      endcase
   endfunction

   // Address capture with the build mode's decoding applied
   function automatic bbs_ach_t f_cap(input bbs_ach_t c);
      bbs_ach_t r;
      r = c;
      // sizes above a word clamp to the bus width
      if (c.size > SIZE_WORD) begin
         r.size = SIZE_WORD;
      end
      // sub-word bits forced to zero outside full memory mode
      // lite modes run single full-width beats
      if (BUILD_MODE != MODE_MEM) begin
         r.addr[WORD_LO-1:0] = '0;
         r.size              = SIZE_WORD;
      end
      if (BUILD_MODE == MODE_LITE_MEM || BUILD_MODE == MODE_LITE_PER) begin
         r.len = 8'h0;
      end
      f_cap = r;
   endfunction

   // ****************************************************************
   // Write side
   // ****************************************************************

   bbs_wst_t          wst_r;
   bbs_wst_t          wst_nxt;
   bbs_ach_t          wch_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [7:0]        wcnt_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic              aw_hs;
   logic              w_hs;
   logic              w_end;
   logic [NBYTES-1:0] ram_we;
   bbs_ach_t          aw_cap;

   assign aw_hs = I_AWVALID && awready_r;
   // Decoded once, so the captured fields and start address agree
   assign aw_cap = f_cap(I_AW);
   assign w_hs  = I_WVALID && wready_r;
   // last beat when the beat count equals the length field
   assign w_end = w_hs && (wcnt_r == wch_r.len);
   // every bus beat is one memory beat
   assign ram_we = w_hs ? I_WSTRB : '0;

   // Write state sequencing
   always_comb begin
      wst_nxt = wst_r;
      unique case (wst_r)
         WS_IDLE: if (aw_hs) wst_nxt = WS_DATA;
         WS_DATA: if (w_end) wst_nxt = WS_RESP;
         WS_RESP: if (I_BREADY) wst_nxt = WS_IDLE;
         default: wst_nxt = WS_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         wst_r <= WS_IDLE;
      end else begin
         wst_r <= wst_nxt;
      end
   end

   // Channel handshakes follow the next state, so each is a flop
   // address ready idles high
   // response raised after the last beat
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
      end else begin
         awready_r <= (wst_nxt == WS_IDLE);
         wready_r  <= (wst_nxt == WS_DATA);
         bvalid_r  <= (wst_nxt == WS_RESP);
      end
   end

   // Write burst address and beat count
   // word index moves only when byte address crosses a word
   // lanes track the byte address in the strobes
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         wch_r   <= '0;
         waddr_r <= '0;
         wcnt_r  <= '0;
      end else if (aw_hs) begin
         wch_r   <= aw_cap;
         waddr_r <= aw_cap.addr[ADDR_W-1:0];
         wcnt_r  <= 8'h0;
      end else if (w_hs) begin
         waddr_r <= f_next(waddr_r, wch_r);
         wcnt_r  <= 8'(wcnt_r + 8'h1);
      end
   end

   // ****************************************************************
   // Memory array, one bank per byte lane
   // ****************************************************************

   logic [IDX_W-1:0]  ridx;
   logic [IDX_W-1:0]  widx;
   logic              issue;
   wire  [DATA_W-1:0] ram_q;

   // 4 kB decoded as 1024 words; the write strobes pick lanes
   assign widx = waddr_r[ADDR_W-1:WORD_LO];

   for (genvar g = 0; g < NBYTES; g++) begin : g_lane
      logic [7:0] bank [MEM_DEPTH];
      logic [7:0] q_r;
      always_ff @(posedge I_CLK) begin
         if (ram_we[g]) begin
            bank[widx] <= I_WDATA[8*g +: 8];
         end
         if (issue) begin
            q_r <= bank[ridx];
         end
      end
      assign ram_q[8*g +: 8] = q_r;
   end

   // ****************************************************************
   // Read side
   // ****************************************************************

   bbs_rst_t          rst_r;
   bbs_rst_t          rst_nxt;
   bbs_ach_t          rch_r;
   logic [ADDR_W-1:0] raddr_r;
   logic [7:0]        rcnt_r;
   logic              arready_r;
   logic              rd_pend_r;
   logic              rd_last_r;
   logic              ar_hs;
   logic              r_end;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_pop;
   logic [CNT_W-1:0]  fifo_cnt;
   bbs_rbeat_t        fifo_out;
   logic              rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic              rlast_r;
   bbs_ach_t          ar_cap;

   assign ar_hs = I_ARVALID && arready_r;
   assign ar_cap = f_cap(I_AR);
   assign ridx  = raddr_r[ADDR_W-1:WORD_LO];
   // Issue only with room for the beat already in flight
   assign issue = (rst_r == RS_BURST) && fifo_in_ready
                  && ((5'(fifo_cnt) + 5'(rd_pend_r)) < 5'(FIFO_DEPTH));
   // burst ends after length plus one reads
   assign r_end = issue && (rcnt_r == rch_r.len);

   // Read state sequencing
   always_comb begin
      rst_nxt = rst_r;
      unique case (rst_r)
         RS_IDLE:  if (ar_hs) rst_nxt = RS_BURST;
         RS_BURST: if (r_end) rst_nxt = RS_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         rst_r     <= RS_IDLE;
         arready_r <= 1'b1;
      end else begin
         rst_r     <= rst_nxt;
         arready_r <= (rst_nxt == RS_IDLE);
      end
   end

   // Read burst address, count and the beat in flight from memory
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         rch_r     <= '0;
         raddr_r   <= '0;
         rcnt_r    <= '0;
         rd_pend_r <= 1'b0;
         rd_last_r <= 1'b0;
      end else begin
         rd_pend_r <= issue;
         rd_last_r <= r_end;
         if (ar_hs) begin
            rch_r   <= ar_cap;
            raddr_r <= ar_cap.addr[ADDR_W-1:0];
            rcnt_r  <= 8'h0;
         end else if (issue) begin
            raddr_r <= f_next(raddr_r, rch_r);
            rcnt_r  <= 8'(rcnt_r + 8'h1);
         end
      end
   end

   // Buffer between memory and the read data channel
   bbs_fifo #(
      .WIDTH (RBEAT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rfifo (
      .i_clk       (I_CLK),
      .i_nrst      (I_NRST),
      .i_in_valid  (rd_pend_r),
      .i_in_data   ({ram_q, rd_last_r}),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out),
      .i_out_ready (fifo_pop),
      .o_count     (fifo_cnt)
   );

   // output slot refills in the accepting cycle
   // slot holds while the master stalls
   assign fifo_pop = fifo_out_valid && (!rvalid_r || I_RREADY);

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rlast_r  <= 1'b0;
      end else if (fifo_pop) begin
         rvalid_r <= 1'b1;
         rdata_r  <= fifo_out.data;
         rlast_r  <= fifo_out.last;
      end else if (I_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign O_AWREADY = awready_r;
   assign O_WREADY  = wready_r;
   assign O_BVALID  = bvalid_r;
   assign O_BRESP   = RESP_OKAY;
   assign O_ARREADY = arready_r;
   assign O_RVALID  = rvalid_r;
   assign O_RDATA   = rdata_r;
   assign O_RRESP   = RESP_OKAY;
   assign O_RLAST   = rlast_r;

   // ****************************************************************
   // Checks
   // ****************************************************************

   a_aw_idle_ready: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (wst_r == WS_IDLE) |-> O_AWREADY)
      else $error("write address ready low while idle");

   a_wready_follows: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_AWVALID && O_AWREADY) |=> (O_WREADY && !O_AWREADY))
      else $error("write data ready did not follow address");

   a_bresp_after_last: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      w_end |=> (O_BVALID && !O_WREADY))
      else $error("write response missing after last beat");

   a_bresp_held: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (O_BVALID && !I_BREADY) |=> O_BVALID)
      else $error("write response dropped before ready");

   a_ar_idle_ready: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (rst_r == RS_IDLE) |-> O_ARREADY)
      else $error("read address ready low while idle");

   a_rdata_stall: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (O_RVALID && !I_RREADY) |=>
         (O_RVALID && $stable(O_RDATA) && $stable(O_RLAST)))
      else $error("read beat changed under stall");

   a_rbeat_next: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (O_RVALID && I_RREADY && fifo_out_valid) |=> O_RVALID)
      else $error("wait cycle inserted between buffered read beats");

   a_rburst_end: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      r_end |=> (rst_r == RS_IDLE) ##1 rd_last_r == 1'b0)
      else $error("read burst did not end at its length");

   a_wrap_region: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (w_hs && !w_end && wch_r.burst == BURST_WRAP) |=>
         (((waddr_r ^ $past(waddr_r)) & ~f_wmask(wch_r)) == '0))
      else $error("wrap address left its region");

   a_strobe_lanes: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_WVALID && O_WREADY) |-> (ram_we == I_WSTRB))
      else $error("lane enables differ from strobes");

endmodule

// ==== testbench/bbs_master_model.sv ====
// Behavioural AXI4 master standing in front of the burst slave.
// Assumes one caller at a time; every call begins on a fresh clock edge.

`timescale 1ns/10ps

module bbs_master_model
   import bbs_pkg::*;
(
   input  wire logic              i_clk,
   output logic                   o_awvalid,
   output bbs_ach_t               o_aw,
   input  wire logic              i_awready,
   output logic                   o_wvalid,
   output logic [DATA_W-1:0]      o_wdata,
   output logic [NBYTES-1:0]      o_wstrb,
   output logic                   o_wlast,
   input  wire logic              i_wready,
   input  wire logic              i_bvalid,
   output logic                   o_bready,
   output logic                   o_arvalid,
   output bbs_ach_t               o_ar,
   input  wire logic              i_arready,
   input  wire logic              i_rvalid,
   input  wire logic [DATA_W-1:0] i_rdata,
   input  wire logic              i_rlast,
   output logic                   o_rready
);

   // ****************************************************************
   // Idle levels
   // ****************************************************************

   // Channels start quiet so reset sees no stray request
   initial begin
      o_awvalid = 1'b0;
      o_aw      = '0;
      o_wvalid  = 1'b0;
      o_wdata   = '0;
      o_wstrb   = '0;
      o_wlast   = 1'b0;
      o_bready  = 1'b0;
      o_arvalid = 1'b0;
      o_ar      = '0;
      o_rready  = 1'b0;
   end

   // ****************************************************************
   // Transfers
   // ****************************************************************

   function automatic bbs_ach_t legal(input bbs_ach_t c);
      if (c.burst == BURST_WRAP) begin
         c.len = (c.len < 2) ? 8'h1 : (c.len < 4) ? 8'h3 :
                 (c.len < 8) ? 8'h7 : 8'hf;
      end
      return c;
   endfunction

   // Whole write burst; prompt tells if the response beat the ready
   task automatic wr(input bbs_ach_t c,
                     input logic [DATA_W-1:0] d [0:255],
                     input logic [NBYTES-1:0] s [0:255],
                     output logic prompt);
      int i;
      c = legal(c);
      @(posedge i_clk);
      o_aw <= c;
      o_awvalid <= 1'b1;
      do @(posedge i_clk); while (i_awready !== 1'b1);
      o_awvalid <= 1'b0;
      o_aw <= ~c;  // Released lines must not look valid
      for (i = 0; i <= c.len; i++) begin
         o_wvalid <= 1'b1;
         o_wdata <= d[i];
         o_wstrb <= s[i];
         o_wlast <= (i == c.len);
         do @(posedge i_clk); while (i_wready !== 1'b1);
      end
      o_wvalid <= 1'b0;
      o_wlast <= 1'b0;
      o_wdata <= ~d[c.len];
      @(posedge i_clk);
      prompt = (i_bvalid === 1'b1);
      o_bready <= 1'b1;
      do @(posedge i_clk); while (i_bvalid !== 1'b1);
      o_bready <= 1'b0;
   endtask

   // Whole read burst; stall bit k holds ready low in cycle k
   task automatic rd(input bbs_ach_t c, input logic [31:0] stall,
                     output logic [DATA_W-1:0] gd [0:255],
                     output logic gl [0:255], output logic held);
      int i;
      int k;
      logic [DATA_W-1:0] prev;
      logic pv;
      c = legal(c);
      @(posedge i_clk);
      o_ar <= c;
      o_arvalid <= 1'b1;
      do @(posedge i_clk); while (i_arready !== 1'b1);
      o_arvalid <= 1'b0;
      o_ar <= ~c;
      i = 0;
      k = 0;
      pv = 1'b0;
      held = 1'b1;
      prev = '0;
      while (i <= c.len) begin
         o_rready <= ~stall[k % 32];
         k++;
         @(posedge i_clk);
         if (pv && (i_rdata !== prev)) held = 1'b0;
         pv = (i_rvalid === 1'b1) && (o_rready === 1'b0);
         prev = i_rdata;
         if ((i_rvalid === 1'b1) && (o_rready === 1'b1)) begin
            gd[i] = i_rdata;
            gl[i] = i_rlast;
            i++;
         end
      end
      o_rready <= 1'b0;
   endtask

endmodule

// ==== testbench/axi_bram_burst_slave_tb.sv ====
// Self-checking bench for the burst slave, driven by the master model.
// Assumes the slave decodes 12 address bits of a 1024-word memory.

`timescale 1ns/10ps

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
   fail_count++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
   end end

module axi_bram_burst_slave_tb;
   import bbs_pkg::*;

   localparam int LIMIT = 30000;  // Cycles; the full run needs about 3200

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              awvalid, awready, wvalid, wlast, wready;
   logic              bvalid, bready, arvalid, arready, rvalid;
   logic              rlast, rready;
   bbs_ach_t          aw, ar;
   logic [DATA_W-1:0] wdata, rdata;
   logic [NBYTES-1:0] wstrb;
   logic [1:0]        bresp, rresp;
   int                fail_count = 0;
   int                comparisons = 0;
   int                cycles = 0;
   int                seed;
   logic [7:0]        ref_mem [0:4095];

   always #10 clk = ~clk;

   bbs_slave bbs_slave_i (.I_CLK(clk), .I_NRST(nrst),
      .I_AWVALID(awvalid), .I_AW(aw), .O_AWREADY(awready),
      .I_WVALID(wvalid), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .I_WLAST(wlast), .O_WREADY(wready), .O_BVALID(bvalid),
      .O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arvalid),
      .I_AR(ar), .O_ARREADY(arready), .O_RVALID(rvalid),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RLAST(rlast),
      .I_RREADY(rready));

   bbs_master_model bbs_master_model_i (.i_clk(clk),
      .o_awvalid(awvalid), .o_aw(aw), .i_awready(awready),
      .o_wvalid(wvalid), .o_wdata(wdata), .o_wstrb(wstrb),
      .o_wlast(wlast), .i_wready(wready), .i_bvalid(bvalid),
      .o_bready(bready), .o_arvalid(arvalid), .o_ar(ar),
      .i_arready(arready), .i_rvalid(rvalid), .i_rdata(rdata),
      .i_rlast(rlast), .o_rready(rready));

   // ****************************************************************
   // Expectations
   // ****************************************************************

   // Byte address of beat i; later INCR and WRAP beats step from the aligned start, FIXED beats keep the start
   function automatic logic [11:0] baddr(bbs_ach_t c, int i);
      logic [11:0] nb;
      logic [11:0] a;
      logic [11:0] wr;
      nb = 12'h1 << c.size;
      a = c.addr[11:0] & ~(nb - 12'h1);
      if ((i == 0) || (c.burst == BURST_FIXED)) return c.addr[11:0];
      if (c.burst == BURST_WRAP) begin
         wr = 12'(nb * (c.len + 1));
         return (a & ~(wr - 12'h1)) | (12'(a + nb * i) & (wr - 12'h1));
      end
      return 12'(a + nb * i);
   endfunction

   // Lanes a beat may use: from its byte up to its size container end
   function automatic logic [3:0] lanes(logic [11:0] a, logic [2:0] sz);
      logic [3:0] m;
      m = (sz == SIZE_HALF) ? (4'h3 << {a[1], 1'b0}) : 4'hf;
      return m & (4'hf << a[1:0]);
   endfunction

   // Write a burst, read it back, compare every beat with the model
   task automatic run(input bbs_ach_t c, input logic full,
                      input logic [31:0] stall);
      logic [DATA_W-1:0] d [0:255];
      logic [NBYTES-1:0] s [0:255];
      logic [DATA_W-1:0] gd [0:255];
      logic              gl [0:255];
      logic              prompt;
      logic              held;
      logic [11:0]       a;
      logic [DATA_W-1:0] e;
      int                i;
      int                b;
      for (i = 0; i <= c.len; i++) begin
         a = baddr(c, i);
         d[i] = $random(seed);
         s[i] = lanes(a, c.size) & (full ? 4'hf : 4'($random(seed)));
         for (b = 0; b < 4; b++) begin
            if (s[i][b]) ref_mem[{a[11:2], 2'(b)}] = d[i][8*b +: 8];
         end
      end
      bbs_master_model_i.wr(c, d, s, prompt);
      `CHK("response before ready", 1'b1, prompt)
      `CHK("write response code", RESP_OKAY, bresp)
      bbs_master_model_i.rd(c, stall, gd, gl, held);
      `CHK("stalled beat held", 1'b1, held)
      `CHK("read response code", RESP_OKAY, rresp)
      for (i = 0; i <= c.len; i++) begin
         a = baddr(c, i);
         e = {ref_mem[{a[11:2], 2'h3}], ref_mem[{a[11:2], 2'h2}],
              ref_mem[{a[11:2], 2'h1}], ref_mem[{a[11:2], 2'h0}]};
         `CHK("read word", e, gd[i])
         `CHK("read last", (i == c.len), gl[i])
      end
   endtask

   // ****************************************************************
   // Run control
   // ****************************************************************

   task automatic finish_test;
      if ((fail_count == 0) && (comparisons > 0))
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // A hang counts as a failure and still reaches the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      bbs_ach_t c;
      int k;
      int n;
      seed = 32'h684f7bee;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("write address idle", 1'b1, awready)
      `CHK("write data idle", 1'b0, wready)
      `CHK("read address idle", 1'b1, arready)
      // Fill all 4 kB with maximum-length bursts of full words
      for (k = 0; k < 4; k++) begin
         c = '{addr: 32'(k * 1024), len: 8'hff, size: SIZE_WORD,
               burst: BURST_INCR};
         run(c, 1'b1, 32'h0);
      end
      // Wrap lengths 2, 4, 8 and 16 for half words and words
      for (k = 0; k < 8; k++) begin
         n = (2 << (k % 4)) - 1;
         c = '{addr: 32'h1008, len: 8'(n), size: (k < 4) ? SIZE_WORD :
               SIZE_HALF, burst: BURST_WRAP};
         run(c, k[0], 32'h0000_0a0a);
      end
      // Narrow half-word burst moving across the lanes
      c = '{addr: 32'h1002, len: 8'h3, size: SIZE_HALF, burst: BURST_INCR};
      run(c, 1'b1, 32'h0);
      // Word burst starting at a half-word offset
      c = '{addr: 32'h1002, len: 8'h3, size: SIZE_WORD, burst: BURST_INCR};
      run(c, 1'b1, 32'h0);
      // Fixed burst rewrites one word, then reads it back every beat
      c = '{addr: 32'h0100, len: 8'h3, size: SIZE_WORD, burst: BURST_FIXED};
      run(c, 1'b0, 32'h0);
      // Long stall fills the read buffer before it drains
      c = '{addr: 32'h0040, len: 8'hf, size: SIZE_WORD, burst: BURST_INCR};
      run(c, 1'b1, 32'h000f_ffff);
      // Random mix of types, sizes, lengths, strobes and stalls
      for (k = 0; k < 24; k++) begin
         c.burst = ($random(seed) & 1) ? BURST_WRAP : BURST_INCR;
         c.size = ($random(seed) & 1) ? SIZE_WORD : SIZE_HALF;
         c.len = 8'($random(seed) & 15);
         c.addr = 32'($random(seed) & 32'h0000_0f7f);
         if (c.burst == BURST_WRAP) begin
            // Legal wrap length here, so expectations use the sent length
            c.len = 8'((2 << ($random(seed) & 3)) - 1);
            c.addr = c.addr & ~((32'h1 << c.size) - 1);
         end
         run(c, 1'b0, 32'($random(seed)) & 32'h5555_5555);
      end
      finish_test();
   end

endmodule
